// >>> wdc_chk_asserts.sv
// Purpose: port-level checks for wdc_top
// Assumes: fuse only changes while SRST is held
// Notes:   bound to wdc_top at the foot of this file
`timescale 1ns/100ps
module wdc_chk (
  // clock and reset
  input wire       MCLK,
  input wire       SRST,
  // register port
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire       REG_WR,
  input wire       REG_RD,
  input wire [7:0] REG_RDATA,
  // core side
  input wire       SAFETY_LEVEL_FUSE,
  input wire       RESTART_INSTR,
  input wire       GLOBAL_IRQ_EN,
  input wire       IRQ_VECTOR_TAKEN,
  // outputs
  input wire       TIMEOUT_IRQ,
  input wire       WDT_RESET_PULSE,
  input wire       WDT_RUNNING
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SRST);
  sequence s_unlock;
    REG_WR && REG_ADDR == 8'h21 && REG_WDATA[4] && REG_WDATA[3];
  endsequence
  sequence s_rd_ctrl;
    REG_RD && REG_ADDR == 8'h21;
  endsequence
  // fuse goes through a synchroniser, so look three edges back
  sequence s_lvl2;
    $past(SAFETY_LEVEL_FUSE, 3) && !$past(SRST, 3);
  endsequence
  a_window_open: assert property (s_unlock ##1 s_rd_ctrl |=> REG_RDATA[4])
    else $error("unlock window not open");
  a_window_shut: assert property (s_unlock ##1 !REG_WR [*5] ##1 s_rd_ctrl |=> !REG_RDATA[4])
    else $error("unlock window left open");
  a_lvl2_read: assert property (s_lvl2 ##0 s_rd_ctrl |=> REG_RDATA[3])
    else $error("enable reads zero at level two");
  a_lvl2_run: assert property (s_lvl2 |-> WDT_RUNNING)
    else $error("watchdog stopped at level two");
  a_cause_rsvd: assert property (REG_RD && REG_ADDR == 8'h22 |=> REG_RDATA[7:4] == 4'h0)
    else $error("reserved cause bits not zero");
  a_irq_gate: assert property (TIMEOUT_IRQ |-> GLOBAL_IRQ_EN)
    else $error("interrupt without global enable");
  a_ack_clear: assert property (IRQ_VECTOR_TAKEN |=> !TIMEOUT_IRQ)
    else $error("interrupt kept after vector taken");
  a_pulse_one: assert property (WDT_RESET_PULSE |=> !WDT_RESET_PULSE)
    else $error("reset pulse longer than one cycle");
  a_pulse_cause: assert property (WDT_RESET_PULSE |-> $past(WDT_RUNNING))
    else $error("reset pulse from stopped watchdog");
  a_restart_hold: assert property (RESTART_INSTR |=> !WDT_RESET_PULSE)
    else $error("reset pulse right after restart");
endmodule // wdc_chk

bind wdc_top wdc_chk u_chk (.MCLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
  .SAFETY_LEVEL_FUSE, .RESTART_INSTR, .GLOBAL_IRQ_EN, .IRQ_VECTOR_TAKEN, .TIMEOUT_IRQ,
  .WDT_RESET_PULSE, .WDT_RUNNING);

// >>> wdc_core_mdl.sv
// Purpose: core and slow oscillator stand-in for wdc_top
// Assumes: oscillator at a quarter of MCLK to keep periods short
// Notes:   vector taken two cycles after each interrupt request
`timescale 1ns/100ps
module wdc_core_mdl (
  // clock
  input  wire  mclk,
  // watchdog side
  input  wire  timeout_irq,
  output logic wdosc_clk,
  output logic irq_vector_taken
);
  logic [1:0] div_ff = 2'h0;
  logic [1:0] ack_ff = 2'h0;
  always @(posedge mclk) begin
    div_ff <= div_ff + 2'h1;
    // one acknowledge per request, none while one is in flight
    ack_ff <= {ack_ff[0], timeout_irq & ~|ack_ff};
  end
  assign wdosc_clk        = div_ff[1];
  assign irq_vector_taken = ack_ff[1];
endmodule // wdc_core_mdl

// >>> wdc_regs.vh
// Purpose: register map, field positions and timing counts of the watchdog control block
// Assumes: 8-bit register port, byte offsets as decoded by the core's I/O space
// Notes:   definitions only
`ifndef WDC_REGS_VH
`define WDC_REGS_VH

// register offsets
`define WDC_ADDR_CTRL      8'h21
`define WDC_ADDR_CAUSE     8'h22

// control/status fields
`define WDC_B_IRQ_FLAG     7
`define WDC_B_IRQ_EN       6
`define WDC_B_PSEL_HI      5
`define WDC_B_UNLOCK       4
`define WDC_B_ENABLE       3
`define WDC_B_PSEL_LO_H    2
`define WDC_B_PSEL_LO_L    0

// reset cause fields
`define WDC_B_WDOG_CAUSE   3
`define WDC_B_BROWN_CAUSE  2
`define WDC_B_PIN_CAUSE    1
`define WDC_B_POWER_CAUSE  0
`define WDC_CAUSE_RSVD     4'h0

// reset values
`define WDC_RST_PSEL       4'h0
`define WDC_RST_UNLOCK     3'h0
`define WDC_RST_COUNT      20'h00000
`define WDC_RST_BYTE       8'h00

// unlock window length in system clock cycles
`define WDC_UNLOCK_CYCLES  3'h4
`define WDC_UNLOCK_STEP    3'h1

// period: 2048 oscillator cycles shifted left by the select code
`define WDC_OSC_KHZ        128
`define WDC_PERIOD_BASE    21'h000800
`define WDC_PERIOD_ONE     21'h000001
`define WDC_PSEL_MAX       4'h9
`define WDC_COUNT_STEP     20'h00001

`endif

// >>> wdc_tb.sv
// Purpose: self-checking bench for wdc_top
// Assumes: oscillator model at MCLK/4, period code 0 for timeouts
// Notes:   random cause traffic and period codes from a fixed seed
`timescale 1ns/100ps
`include "wdc_regs.vh"
module testbench;
  localparam logic [7:0] C = `WDC_ADDR_CTRL;
  localparam logic [7:0] K = `WDC_ADDR_CAUSE;
  logic       MCLK = 1'b0, SRST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, RESTART_INSTR = 1'b0;
  logic       SAFETY_LEVEL_FUSE = 1'b0, POR_EVT = 1'b0, BOR_EVT = 1'b0, PIN_EVT = 1'b0;
  logic       GLOBAL_IRQ_EN = 1'b0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, exp_c, w;
  logic [3:0] p;
  wire  [7:0] REG_RDATA;
  wire        WDOSC_CLK, IRQ_VECTOR_TAKEN, TIMEOUT_IRQ, WDT_RESET_PULSE, WDT_RUNNING;
  int         miscompares = 0, total_checks = 0, n;
  always #5 MCLK = ~MCLK;
  wdc_top dut (.MCLK, .SRST, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .WDOSC_CLK,
    .SAFETY_LEVEL_FUSE, .POR_EVT, .BOR_EVT, .PIN_EVT, .RESTART_INSTR, .GLOBAL_IRQ_EN,
    .IRQ_VECTOR_TAKEN, .TIMEOUT_IRQ, .WDT_RESET_PULSE, .WDT_RUNNING);
  wdc_core_mdl core (.mclk(MCLK), .timeout_irq(TIMEOUT_IRQ), .wdosc_clk(WDOSC_CLK),
    .irq_vector_taken(IRQ_VECTOR_TAKEN));
  function automatic logic [7:0] ctrl(input logic ie, en, input logic [3:0] ps);
    return {1'b0, ie, ps[3], 1'b0, en, ps[2:0]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic idle(input int k);
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    repeat (k) @(posedge MCLK);
  endtask
  // leaves the strobe high so writes can run back to back
  task automatic wr(input logic [7:0] a, dat);
    REG_RD <= 1'b0;
    REG_ADDR <= a;
    REG_WDATA <= dat;
    REG_WR <= 1'b1;
    @(posedge MCLK);
  endtask
  task automatic rd(input logic [7:0] a, exp, input string nm);
    REG_WR <= 1'b0;
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge MCLK);
    REG_RD <= 1'b0;
    #1 chk(nm, REG_RDATA, exp);
    @(posedge MCLK);
  endtask
  task automatic unl(input logic [7:0] dat);
    wr(C, 8'h18);
    wr(C, dat);
    idle(5);
  endtask
  task automatic wait_for(input logic s, input int lim);
    n = 0;
    while ((s ? TIMEOUT_IRQ : WDT_RESET_PULSE) !== 1'b1 && n < lim) begin
      @(posedge MCLK);
      #1 n++;
    end
    chk("wait", 8'(n < lim), 8'h01);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #800us;
    miscompares++;
    end_of_test;
  end
  initial begin
    void'($urandom(32'h1666cdb9));
    repeat (2) @(posedge MCLK);
    SRST <= 1'b0;
    POR_EVT <= 1'b1;
    idle(4);
    {POR_EVT, BOR_EVT, PIN_EVT} <= 3'b011;
    idle(4);
    rd(K, 8'h07, "events");
    {POR_EVT, BOR_EVT, PIN_EVT} <= 3'b100;
    idle(4);
    POR_EVT <= 1'b0;
    rd(K, 8'h01, "power on");
    exp_c = 8'h01;
    for (int i = 0; i < 8; i++) begin
      w = 8'($urandom);
      {BOR_EVT, PIN_EVT} <= w[2:1];
      idle(4);
      {BOR_EVT, PIN_EVT} <= 2'b00;
      exp_c = (exp_c | (w & 8'h06)) & 8'($urandom);
      wr(K, exp_c | 8'hf0);
      rd(K, exp_c, "cause");
    end
    wr(K, 8'h00);
    rd(8'h23, 8'h00, "unmapped");
    rd(C, 8'h00, "ctrl reset");
    wr(C, 8'h08);
    wr(C, 8'h00);
    rd(C, 8'h08, "locked");
    wr(C, 8'h18);
    rd(C, 8'h18, "open");
    idle(3);
    rd(C, 8'h08, "shut");
    wr(C, 8'h00);
    rd(C, 8'h08, "late clear");
    unl(8'h00);
    rd(C, 8'h00, "disable");
    for (int i = 0; i < 4; i++) begin
      p = 4'($urandom_range(9));
      unl(ctrl(1'b0, 1'b0, p));
      rd(C, ctrl(1'b0, 1'b0, p), "period");
    end
    wr(C, ctrl(1'b0, 1'b0, ~p));
    rd(C, ctrl(1'b0, 1'b0, p), "period locked");
    unl(8'h08);
    idle(3000);
    RESTART_INSTR <= 1'b1;
    idle(1);
    RESTART_INSTR <= 1'b0;
    wait_for(1'b0, 9000);
    chk("period", 8'(n > 8150 && n < 8260), 8'h01);
    rd(K, 8'h08, "wdog cause");
    unl(8'h00);
    rd(C, 8'h08, "forced");
    wr(K, 8'h00);
    unl(8'h00);
    rd(C, 8'h00, "cleared");
    GLOBAL_IRQ_EN <= 1'b1;
    wr(C, 8'h40);
    idle(1);
    wait_for(1'b1, 9000);
    idle(4);
    #1 chk("acked", 8'(TIMEOUT_IRQ), 8'h00);
    rd(C, 8'h40, "irq kept");
    wr(C, 8'h48);
    idle(1);
    wait_for(1'b0, 17000);
    chk("second", 8'(n > 8300), 8'h01);
    rd(C, 8'h88, "flag");
    wr(C, 8'h88);
    rd(C, 8'h08, "flag clear");
    wr(K, 8'h00);
    unl(8'h00);
    rd(C, 8'h00, "level one off");
    #1 chk("stopped", 8'(WDT_RUNNING), 8'h00);
    @(posedge MCLK);
    SAFETY_LEVEL_FUSE <= 1'b1;
    SRST <= 1'b1;
    idle(4);
    SRST <= 1'b0;
    rd(C, 8'h08, "level two");
    #1 chk("l2 running", 8'(WDT_RUNNING), 8'h01);
    @(posedge MCLK);
    unl(8'h00);
    rd(C, 8'h08, "no stop");
    unl(8'h01);
    rd(C, 8'h09, "l2 period");
    end_of_test;
  end
endmodule // testbench

// >>> wdc_top.v
// Purpose: watchdog control, protected configuration and reset cause flags
// Assumes: oscillator and strap arrive from outside the MCLK domain; core
//          signals (restart, global enable, vector taken) are MCLK-synchronous
// Notes:   cause flags survive SRST; only a power-on event reinitialises them
//
// Functional notes
// - level one: starts off, enable by writing one
// - level two: always runs, enable reads one
// - level two: period change via unlock window
// - level two: disable sequence never stops it
// - cause register upper four bits read zero
// - watchdog cause flag: set, cleared by POR/write
// - brown-out cause flag: set, cleared by POR/write
// - pin cause flag: set, cleared by POR/write
// - power-on flag cleared only by software
// - irq flag set on timeout, cleared by ack/write-one
// - interrupt requested only with both enables
// - timeout action follows enable pair table
// - timeout clears irq enable when enable set
// - unlock bit self-clears after four cycles
// - enable clears only inside unlock window
// - period select changes only inside window
// - level one: cause flag forces enable on
// - period codes 0..9 give 2K..1024K cycles
// - period select at bits 5 and 2..0
// - strap selects safety level and initial state
// - counter runs from separate slow oscillator
// - watchdog reset pulse lasts one cycle
// - counter cleared by restart, disable, reset
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`include "wdc_regs.vh"

module wdc_top (
  // clock and reset
  MCLK,
  SRST,
  // register port
  REG_ADDR,
  REG_WDATA,
  REG_WR,
  REG_RD,
  REG_RDATA,
  // asynchronous inputs
  WDOSC_CLK,
  SAFETY_LEVEL_FUSE,
  POR_EVT,
  BOR_EVT,
  PIN_EVT,
  // core side
  RESTART_INSTR,
  GLOBAL_IRQ_EN,
  IRQ_VECTOR_TAKEN,
  // outputs
  TIMEOUT_IRQ,
  WDT_RESET_PULSE,
  WDT_RUNNING
);
  // clock and reset
  input  wire       MCLK;
  input  wire       SRST;
  // register port
  input  wire [7:0] REG_ADDR;
  input  wire [7:0] REG_WDATA;
  input  wire       REG_WR;
  input  wire       REG_RD;
  output wire [7:0] REG_RDATA;
  // asynchronous inputs
  input  wire       WDOSC_CLK;
  input  wire       SAFETY_LEVEL_FUSE;
  input  wire       POR_EVT;
  input  wire       BOR_EVT;
  input  wire       PIN_EVT;
  // core side
  input  wire       RESTART_INSTR;
  input  wire       GLOBAL_IRQ_EN;
  input  wire       IRQ_VECTOR_TAKEN;
  // outputs
  output wire       TIMEOUT_IRQ;
  output wire       WDT_RESET_PULSE;
  output wire       WDT_RUNNING;

  // terminal count for a period code
  function [19:0] period_last;
    input [3:0] sel;
    reg   [3:0] eff;
    reg   [20:0] span;
    begin
      eff  = (sel > `WDC_PSEL_MAX) ? `WDC_PSEL_MAX : sel;
      span = (`WDC_PERIOD_BASE << eff) - `WDC_PERIOD_ONE;
      period_last = span[19:0];
    end
  endfunction

  // exact match of a register offset against the bus address
  function addr_hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // a cause bit survives a write only where the written bit is one
  function cause_keep;
    input wr_en;
    input wr_bit;
    input cur;
    begin
      cause_keep = cur & ~(wr_en & ~wr_bit);
    end
  endfunction

  // synchronisers: first stage feeds only the second
  reg  [4:0] sync1_ff;
  reg  [4:0] sync2_ff;
  reg  [3:0] edge_ff;
  wire [4:0] async_in;

  assign async_in = {SAFETY_LEVEL_FUSE, PIN_EVT, BOR_EVT, POR_EVT, WDOSC_CLK};

  localparam N_ASYNC = 5;
  localparam N_EVENT = 4;

  genvar gi;
  generate
    for (gi = 0; gi < N_ASYNC; gi = gi + 1) begin : g_sync
      always @(posedge MCLK) begin
        sync1_ff[gi] <= async_in[gi];
        sync2_ff[gi] <= sync1_ff[gi];
      end
    end
    // edge history is taken from the second stage only
    for (gi = 0; gi < N_EVENT; gi = gi + 1) begin : g_edge
      always @(posedge MCLK) begin
        edge_ff[gi] <= sync2_ff[gi];
      end
    end
  endgenerate

  wire level_two;
  wire osc_tick;
  wire por_rise;
  wire bor_rise;
  wire pin_rise;

  assign level_two = sync2_ff[4];
  assign osc_tick  = sync2_ff[0] & ~edge_ff[0];
  assign por_rise  = sync2_ff[1] & ~edge_ff[1];
  assign bor_rise  = sync2_ff[2] & ~edge_ff[2];
  assign pin_rise  = sync2_ff[3] & ~edge_ff[3];

  // register state
  reg        enable_ff;
  reg        irq_en_ff;
  reg        irq_flag_ff;
  reg  [3:0] psel_ff;
  reg  [2:0] unlock_ff;
  reg  [19:0] count_ff;
  reg        rst_pulse_ff;
  reg        wdog_cause_ff;
  reg        brown_cause_ff;
  reg        pin_cause_ff;
  reg        power_cause_ff;
  reg  [7:0] rdata_ff;

  reg        nxt_enable;
  reg        nxt_irq_en;
  reg        nxt_irq_flag;
  reg  [3:0] nxt_psel;
  reg  [2:0] nxt_unlock;
  reg  [19:0] nxt_count;

  // decode
  wire wr_ctrl;
  wire wr_cause;
  wire rd_ctrl;
  wire rd_cause;
  wire unlock_open;
  wire unlock_start;

  assign wr_ctrl      = REG_WR & addr_hit(REG_ADDR, `WDC_ADDR_CTRL);
  assign wr_cause     = REG_WR & addr_hit(REG_ADDR, `WDC_ADDR_CAUSE);
  assign rd_ctrl      = REG_RD & addr_hit(REG_ADDR, `WDC_ADDR_CTRL);
  assign rd_cause     = REG_RD & addr_hit(REG_ADDR, `WDC_ADDR_CAUSE);
  assign unlock_open  = (unlock_ff != `WDC_RST_UNLOCK);
  assign unlock_start = wr_ctrl & REG_WDATA[`WDC_B_UNLOCK] & REG_WDATA[`WDC_B_ENABLE];

  // effective enable: strap forces it in level two, the cause flag in level one
  wire enable_eff;
  wire running;
  wire at_last;
  wire timeout;
  wire timeout_rst;

  assign enable_eff  = enable_ff | level_two | wdog_cause_ff;
  assign running     = enable_eff | irq_en_ff;
  assign at_last     = (count_ff == period_last(psel_ff));
  assign timeout     = running & osc_tick & at_last & ~RESTART_INSTR;
  assign timeout_rst = timeout & enable_eff & ~irq_en_ff;

  // control register next state
  always @* begin
    nxt_enable   = enable_ff;
    nxt_irq_en   = irq_en_ff;
    nxt_irq_flag = irq_flag_ff;
    nxt_psel     = psel_ff;
    nxt_unlock   = unlock_ff;
    // window counts down; a fresh unlock write reloads it
    if (unlock_start) begin
      nxt_unlock = `WDC_UNLOCK_CYCLES;
    end else if (unlock_open) begin
      nxt_unlock = unlock_ff - `WDC_UNLOCK_STEP;
    end
    if (wr_ctrl) begin
      if (REG_WDATA[`WDC_B_ENABLE]) begin
        nxt_enable = 1'b1;
      end else if (unlock_open) begin
        // in level two this store has no effect on the running state
        nxt_enable = 1'b0;
      end
      if (unlock_open) begin
        nxt_psel = {REG_WDATA[`WDC_B_PSEL_HI],
                    REG_WDATA[`WDC_B_PSEL_LO_H:`WDC_B_PSEL_LO_L]};
      end
      nxt_irq_en = REG_WDATA[`WDC_B_IRQ_EN];
      if (REG_WDATA[`WDC_B_IRQ_FLAG]) begin
        nxt_irq_flag = 1'b0;
      end
    end
    if (IRQ_VECTOR_TAKEN) begin
      nxt_irq_flag = 1'b0;
    end
    // hardware events last so they win over software in the same cycle
    if (timeout & irq_en_ff) begin
      nxt_irq_flag = 1'b1;
    end
    if (timeout & enable_eff) begin
      nxt_irq_en = 1'b0;
    end
  end

  // counter next state
  always @* begin
    nxt_count = count_ff + `WDC_COUNT_STEP;
    if (~running | RESTART_INSTR) begin
      nxt_count = `WDC_RST_COUNT;
    end else if (~osc_tick) begin
      nxt_count = count_ff;
    end else if (at_last) begin
      nxt_count = `WDC_RST_COUNT;
    end
  end

  // control register and counter flops, one per field
  always @(posedge MCLK) begin
    if (SRST) begin
      enable_ff <= 1'b0;
    end else begin
      enable_ff <= nxt_enable;
    end
  end

  always @(posedge MCLK) begin
    if (SRST) begin
      irq_en_ff <= 1'b0;
    end else begin
      irq_en_ff <= nxt_irq_en;
    end
  end

  always @(posedge MCLK) begin
    if (SRST) begin
      irq_flag_ff <= 1'b0;
    end else begin
      irq_flag_ff <= nxt_irq_flag;
    end
  end

  always @(posedge MCLK) begin
    if (SRST) begin
      psel_ff <= `WDC_RST_PSEL;
    end else begin
      psel_ff <= nxt_psel;
    end
  end

  always @(posedge MCLK) begin
    if (SRST) begin
      unlock_ff <= `WDC_RST_UNLOCK;
    end else begin
      unlock_ff <= nxt_unlock;
    end
  end

  always @(posedge MCLK) begin
    if (SRST) begin
      count_ff <= `WDC_RST_COUNT;
    end else begin
      count_ff <= nxt_count;
    end
  end

  // registered so the pulse is exactly one clock wide
  always @(posedge MCLK) begin
    if (SRST) begin
      rst_pulse_ff <= 1'b0;
    end else begin
      rst_pulse_ff <= timeout_rst;
    end
  end

  // reset cause flags: not touched by SRST, so they outlive the resets they record
  always @(posedge MCLK) begin
    if (por_rise) begin
      power_cause_ff <= 1'b1;
    end else begin
      power_cause_ff <= cause_keep(wr_cause, REG_WDATA[`WDC_B_POWER_CAUSE],
                                   power_cause_ff);
    end
  end

  // set wins over a same-cycle software clear
  always @(posedge MCLK) begin
    if (por_rise) begin
      wdog_cause_ff <= 1'b0;
    end else begin
      wdog_cause_ff <= timeout_rst |
                       cause_keep(wr_cause, REG_WDATA[`WDC_B_WDOG_CAUSE], wdog_cause_ff);
    end
  end

  always @(posedge MCLK) begin
    if (por_rise) begin
      brown_cause_ff <= 1'b0;
    end else begin
      brown_cause_ff <= bor_rise |
                        cause_keep(wr_cause, REG_WDATA[`WDC_B_BROWN_CAUSE],
                                   brown_cause_ff);
    end
  end

  always @(posedge MCLK) begin
    if (por_rise) begin
      pin_cause_ff <= 1'b0;
    end else begin
      pin_cause_ff <= pin_rise |
                      cause_keep(wr_cause, REG_WDATA[`WDC_B_PIN_CAUSE], pin_cause_ff);
    end
  end

  // read data stands one cycle after the read strobe, zero otherwise
  reg  [7:0] nxt_rdata;

  always @* begin
    nxt_rdata = `WDC_RST_BYTE;
    if (rd_ctrl) begin
      nxt_rdata = {irq_flag_ff, irq_en_ff, psel_ff[3], unlock_open,
                   enable_eff, psel_ff[2:0]};
    end else if (rd_cause) begin
      nxt_rdata = {`WDC_CAUSE_RSVD, wdog_cause_ff, brown_cause_ff,
                   pin_cause_ff, power_cause_ff};
    end
  end

  always @(posedge MCLK) begin
    if (SRST) begin
      rdata_ff <= `WDC_RST_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA       = rdata_ff;
  assign TIMEOUT_IRQ     = irq_flag_ff & irq_en_ff & GLOBAL_IRQ_EN;
  assign WDT_RESET_PULSE = rst_pulse_ff;
  assign WDT_RUNNING     = running;

endmodule // wdc_top
